/* File: reset_seq_pkg.sv */
// constants and types for the device reset sequencer
// Summary of operation
// [R1] any reset source pulls system reset low; code ignores internal sources in ST_RELEASE and ST_EXEC_WT
// [R2] self-driven reset low at least eight clocks
// [R3] reset vector presented four half-periods after low
// [R4] wait thirty-two half-periods before executing vector
// [R5] supervisor holds power-on reset low at power-up
// [R6] I/Os high impedance within eight clocks
// [R7] open-drain pin, senses external low, never drives high
// [R8] synchronise inputs, release after stable high
package reset_seq_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RS_LOW_MIN_CLK = 8;
    localparam int unsigned VEC_DELAY_HALF = 4;
    localparam int unsigned EXEC_DELAY_HALF = 32;
    localparam int unsigned HIZ_MAX_CLK = 8;
    localparam int unsigned STABLE_CLK = 4;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    typedef enum logic [4:0] {
        ST_POR     = 5'b00001,
        ST_DRIVE   = 5'b00010,
        ST_RELEASE = 5'b00100,
        ST_EXEC_WT = 5'b01000,
        ST_RUN     = 5'b10000
    } seq_state_e;
endpackage

/* File: seq_sync_if.sv */
// carrier between sequencer and its input synchroniser
`timescale 1ns/1ps
interface seq_sync_if;
    logic por_sync_n;
    logic rs_sync_n;
    logic stable_high;
    modport sync (output por_sync_n, output rs_sync_n, output stable_high);
    modport seq (input por_sync_n, input rs_sync_n, input stable_high);
endinterface

/* File: reset_in_sync.sv */
// two-flop synchronisers and stable-high filter for reset inputs
`timescale 1ns/1ps
module reset_in_sync
    import reset_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic power_on_reset_in_n,
    input wire logic system_reset_pin_n,
    seq_sync_if.sync s
);
    logic [1:0] por_meta_reg, por_meta_next;
    logic [1:0] rs_meta_reg, rs_meta_next;
    logic [CNT_W-1:0] stab_reg, stab_next;

    always_comb begin
        por_meta_next = {por_meta_reg[0], power_on_reset_in_n}; // R8
        rs_meta_next = {rs_meta_reg[0], system_reset_pin_n}; // R8
        stab_next = stab_reg;
        if (!por_meta_reg[1] || !rs_meta_reg[1]) begin
            stab_next = CNT_ZERO;
        end else if (stab_reg != CNT_W'(STABLE_CLK)) begin
            stab_next = stab_reg + CNT_ONE; // R8
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            por_meta_reg <= 2'h0;
            rs_meta_reg <= 2'h0;
            stab_reg <= CNT_ZERO;
        end else begin
            por_meta_reg <= por_meta_next;
            rs_meta_reg <= rs_meta_next;
            stab_reg <= stab_next;
        end
    end

    assign s.por_sync_n = por_meta_reg[1];
    assign s.rs_sync_n = rs_meta_reg[1];
    assign s.stable_high = (stab_reg == CNT_W'(STABLE_CLK));
endmodule

/* File: device_reset_sequencer.sv */
// reset sequencer: open-drain reset pin, vector fetch and I/O tri-state
`timescale 1ns/1ps
module device_reset_sequencer
    import reset_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic power_on_reset_in_n,
    input wire logic system_reset_pin_n,
    input wire logic illegal_addr_reset,
    input wire logic soft_reset,
    input wire logic watchdog_reset,
    input wire logic core_clock_output,
    output logic system_reset_pin_oe,
    output logic system_reset_pin_out,
    output logic io_hiz,
    output logic vector_valid,
    output logic [15:0] vector_addr,
    output logic core_run
);
    seq_sync_if s();
    reset_in_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .power_on_reset_in_n(power_on_reset_in_n),
        .system_reset_pin_n(system_reset_pin_n),
        .s(s)
    );

    // half-period edges of the core clock output, sampled through two flops
    logic [2:0] cko_reg, cko_next;
    logic half_tick;
    assign half_tick = cko_reg[2] ^ cko_reg[1];

    seq_state_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] half_reg, half_next;
    logic [CNT_W-1:0] hiz_reg, hiz_next;
    logic oe_reg, oe_next;
    logic io_hiz_reg, io_hiz_next;
    logic vv_reg, vv_next;
    logic run_reg, run_next;
    logic internal_src;
    assign internal_src = illegal_addr_reset | soft_reset | watchdog_reset;

    always_comb begin
        cko_next = {cko_reg[1:0], core_clock_output};
        state_next = state_reg;
        cnt_next = cnt_reg;
        half_next = half_reg;
        hiz_next = hiz_reg;
        oe_next = oe_reg;
        io_hiz_next = io_hiz_reg;
        vv_next = vv_reg;
        run_next = run_reg;
        if (half_tick && half_reg != CNT_W'(EXEC_DELAY_HALF)) begin
            half_next = half_reg + CNT_ONE;
        end
        case (state_reg)
            ST_POR: begin
                oe_next = 1'b1; // R1
                io_hiz_next = 1'b1;
                run_next = 1'b0;
                if (s.por_sync_n) begin
                    state_next = ST_DRIVE;
                    cnt_next = CNT_ZERO;
                    half_next = CNT_ZERO;
                end
            end
            ST_DRIVE: begin
                oe_next = 1'b1; // R1
                if (cnt_reg != CNT_W'(RS_LOW_MIN_CLK)) begin
                    cnt_next = cnt_reg + CNT_ONE;
                end
                if (half_reg >= CNT_W'(VEC_DELAY_HALF)) begin
                    vv_next = 1'b1; // R3
                end
                if (!s.por_sync_n) begin
                    state_next = ST_POR;
                end else if (cnt_reg == CNT_W'(RS_LOW_MIN_CLK) && vv_reg) begin
                    oe_next = 1'b0; // R2
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (s.stable_high) begin
                    state_next = ST_EXEC_WT; // R8
                    half_next = CNT_ZERO;
                end else if (!s.por_sync_n) begin
                    state_next = ST_POR;
                end
            end
            ST_EXEC_WT: begin
                if (!s.por_sync_n || !s.rs_sync_n) begin
                    state_next = ST_DRIVE; // R7
                    oe_next = 1'b1;
                    cnt_next = CNT_ZERO;
                    half_next = CNT_ZERO;
                    vv_next = 1'b0;
                end else if (half_reg == CNT_W'(EXEC_DELAY_HALF)) begin
                    state_next = ST_RUN; // R4
                    run_next = 1'b1;
                    io_hiz_next = 1'b0;
                end
            end
            ST_RUN: begin
                if (!s.por_sync_n || !s.rs_sync_n || internal_src) begin
                    state_next = ST_DRIVE; // R1
                    oe_next = 1'b1;
                    run_next = 1'b0;
                    io_hiz_next = 1'b1;
                    vv_next = 1'b0;
                    cnt_next = CNT_ZERO;
                    half_next = CNT_ZERO;
                end
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
        if (!s.por_sync_n) begin
            vv_next = 1'b0;
            hiz_next = CNT_ZERO;
        end else if (hiz_reg != CNT_W'(HIZ_MAX_CLK)) begin
            hiz_next = hiz_reg + CNT_ONE;
        end
        if (state_next != ST_RUN) begin
            io_hiz_next = 1'b1; // R6
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cko_reg <= 3'h0;
            state_reg <= ST_POR;
            cnt_reg <= CNT_ZERO;
            half_reg <= CNT_ZERO;
            hiz_reg <= CNT_ZERO;
            oe_reg <= 1'b1;
            io_hiz_reg <= 1'b1;
            vv_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            cko_reg <= cko_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            half_reg <= half_next;
            hiz_reg <= hiz_next;
            oe_reg <= oe_next;
            io_hiz_reg <= io_hiz_next;
            vv_reg <= vv_next;
            run_reg <= run_next;
        end
    end

    // open drain: output data is always low, only the enable moves
    assign system_reset_pin_oe = oe_reg; // R7
    assign system_reset_pin_out = 1'b0; // R7
    assign io_hiz = io_hiz_reg;
    assign vector_valid = vv_reg;
    assign vector_addr = RESET_VECTOR;
    assign core_run = run_reg;

    // assertions
    // cycles the pin has been pulled low, saturating
    logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
    always_comb begin
        low_cnt_next = low_cnt_reg;
        if (!oe_reg) begin
            low_cnt_next = CNT_ZERO;
        end else if (low_cnt_reg != {CNT_W{1'b1}}) begin
            low_cnt_next = low_cnt_reg + CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            low_cnt_reg <= CNT_ZERO;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    property p_rs_low_min;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(oe_reg) |-> $past(low_cnt_reg) >= CNT_W'(RS_LOW_MIN_CLK);
    endproperty
    a_rs_low_min: assert property (p_rs_low_min) else $error("reset pin released early"); // R2

    property p_src_drives;
        @(posedge sys_clk) disable iff (!nrst)
        (state_reg == ST_RUN && internal_src) |=> oe_reg && !run_reg;
    endproperty
    a_src_drives: assert property (p_src_drives) else $error("reset source not driving pin"); // R1

    property p_never_high;
        @(posedge sys_clk) disable iff (!nrst)
        system_reset_pin_out == 1'b0;
    endproperty
    a_never_high: assert property (p_never_high) else $error("reset pin driven high"); // R7

    property p_vec_delay;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(vv_reg) |-> half_reg >= CNT_W'(VEC_DELAY_HALF);
    endproperty
    a_vec_delay: assert property (p_vec_delay) else $error("vector presented too early"); // R3

    property p_exec_delay;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(run_reg) |-> $past(half_reg) == CNT_W'(EXEC_DELAY_HALF);
    endproperty
    a_exec_delay: assert property (p_exec_delay) else $error("vector executed too early"); // R4

    property p_hiz_in_reset;
        @(posedge sys_clk) disable iff (!nrst)
        !run_reg |-> io_hiz;
    endproperty
    a_hiz_in_reset: assert property (p_hiz_in_reset) else $error("I/O driven in reset"); // R6

    property p_hiz_settled;
        @(posedge sys_clk) disable iff (!nrst)
        (s.por_sync_n && hiz_reg == CNT_W'(HIZ_MAX_CLK) && !run_reg) |-> io_hiz;
    endproperty
    a_hiz_settled: assert property (p_hiz_settled) else $error("I/O not tri-stated after power-on"); // R6

    property p_ext_low;
        @(posedge sys_clk) disable iff (!nrst)
        (state_reg == ST_RUN && !s.rs_sync_n) |=> !run_reg ##1 oe_reg;
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("external reset not sensed"); // R7

    property p_release_stable;
        @(posedge sys_clk) disable iff (!nrst)
        (state_reg == ST_RELEASE && !s.stable_high) |=> state_reg != ST_EXEC_WT;
    endproperty
    a_release_stable: assert property (p_release_stable) else $error("release before stable"); // R8

    c_por_run: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(run_reg));
    c_soft: cover property (@(posedge sys_clk) disable iff (!nrst) run_reg && soft_reset);
    c_ext: cover property (@(posedge sys_clk) disable iff (!nrst) run_reg && !s.rs_sync_n);
    c_vector: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(vv_reg));
endmodule

/* File: board_reset_model.sv */
// board side: power supervisor, pulled-up reset wire and output clock source
`timescale 1ns/1ps
module board_reset_model (
    input wire logic sys_clk,
    input wire logic por_hold,
    input wire logic ext_pull,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic power_on_reset_in_n,
    output logic system_reset_pin_n,
    output logic core_clock_output
);
    logic [1:0] div_reg = 2'h0;
    // supervisor holds power-on reset low while asked
    assign power_on_reset_in_n = !por_hold;
    // pull-up wins unless a party pulls low; a high drive is ignored
    assign system_reset_pin_n = !((pin_oe && (pin_out == 1'b0)) || ext_pull);
    always_ff @(posedge sys_clk) begin
        div_reg <= div_reg + 2'h1;
    end
    assign core_clock_output = div_reg[1];
endmodule

/* File: device_reset_sequencer_tb_top.sv */
// self-checking bench for the device reset sequencer
`timescale 1ns/1ps
module device_reset_sequencer_tb_top;
    import reset_seq_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic por_hold = 1'b1;
    logic ext_pull = 1'b0;
    logic illegal_addr_reset = 1'b0;
    logic soft_reset = 1'b0;
    logic watchdog_reset = 1'b0;
    logic power_on_reset_in_n, system_reset_pin_n, core_clock_output;
    logic system_reset_pin_oe, system_reset_pin_out, io_hiz, vector_valid, core_run;
    logic [15:0] vector_addr;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #4 sys_clk = ~sys_clk;

    board_reset_model i_board (.sys_clk(sys_clk), .por_hold(por_hold), .ext_pull(ext_pull),
        .pin_oe(system_reset_pin_oe), .pin_out(system_reset_pin_out),
        .power_on_reset_in_n(power_on_reset_in_n), .system_reset_pin_n(system_reset_pin_n),
        .core_clock_output(core_clock_output));

    device_reset_sequencer i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .power_on_reset_in_n(power_on_reset_in_n), .system_reset_pin_n(system_reset_pin_n),
        .illegal_addr_reset(illegal_addr_reset), .soft_reset(soft_reset),
        .watchdog_reset(watchdog_reset), .core_clock_output(core_clock_output),
        .system_reset_pin_oe(system_reset_pin_oe), .system_reset_pin_out(system_reset_pin_out),
        .io_hiz(io_hiz), .vector_valid(vector_valid), .vector_addr(vector_addr),
        .core_run(core_run));

    task automatic compare(input logic [15:0] act, input logic [15:0] exp);
        samples_checked++;
        if (act !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic check_min(input logic [15:0] act, input logic [15:0] lim);
        samples_checked++;
        if (!(act >= lim) || $isunknown(act)) begin
            n_mismatch++;
            $display("Error at %0t: got %h below %h", $time, act, lim);
        end
    endtask

    task automatic print_verdict;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // follows one reset sequence raised at the edge just before the call
    task automatic watch_reset(input logic is_por);
        int n_oe, h_vec, h_ex, t;
        logic seen_low, seen_high, vec_armed, vec_seen, prev_ck, done;
        n_oe = 0;
        h_vec = 0;
        h_ex = 0;
        seen_low = 1'b0;
        seen_high = 1'b0;
        vec_armed = 1'b0;
        vec_seen = 1'b0;
        done = 1'b0;
        prev_ck = core_clock_output;
        for (t = 0; t < 3000 && !done; t++) begin
            @(posedge sys_clk);
            if (t == 0) begin
                soft_reset <= 1'b0;
                illegal_addr_reset <= 1'b0;
                watchdog_reset <= 1'b0;
            end
            if (t == 2) ext_pull <= 1'b0;
            if (t == 5) por_hold <= 1'b0;
            #1;
            if (system_reset_pin_n === 1'b0) seen_low = 1'b1;
            if (seen_low && system_reset_pin_n === 1'b1) seen_high = 1'b1;
            if (system_reset_pin_oe === 1'b1) n_oe++;
            if (core_clock_output !== prev_ck) begin
                if (seen_low && !vec_seen) h_vec++;
                if (seen_high && core_run !== 1'b1) h_ex++;
            end
            prev_ck = core_clock_output;
            if (t == 13 && is_por) compare(io_hiz, 1'b1);
            // vector from the previous run stands until the pin is sensed
            if (seen_low && vector_valid === 1'b0) vec_armed = 1'b1;
            if (vector_valid === 1'b1 && vec_armed && !vec_seen) begin
                vec_seen = 1'b1;
                compare(vector_addr, RESET_VECTOR);
                compare(io_hiz, 1'b1);
            end
            if (system_reset_pin_oe === 1'b1) compare(system_reset_pin_out, 1'b0);
            if (core_run === 1'b1 && seen_high) done = 1'b1;
        end
        compare(done, 1'b1);
        compare(seen_low, 1'b1);
        check_min(n_oe, RS_LOW_MIN_CLK);
        check_min(h_vec, VEC_DELAY_HALF);
        check_min(h_ex, EXEC_DELAY_HALF);
        compare(io_hiz, 1'b0);
    endtask

    task automatic scen_power_on;
        @(posedge sys_clk);
        por_hold <= 1'b1;
        watch_reset(1'b1);
    endtask

    task automatic scen_soft;
        @(posedge sys_clk);
        soft_reset <= 1'b1;
        watch_reset(1'b0);
    endtask

    task automatic scen_illegal;
        @(posedge sys_clk);
        illegal_addr_reset <= 1'b1;
        watch_reset(1'b0);
    endtask

    task automatic scen_watchdog;
        @(posedge sys_clk);
        watchdog_reset <= 1'b1;
        watch_reset(1'b0);
    endtask

    task automatic scen_external;
        @(posedge sys_clk);
        ext_pull <= 1'b1;
        watch_reset(1'b0);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        scen_power_on();
        repeat (5) @(posedge sys_clk);
        scen_soft();
        repeat (5) @(posedge sys_clk);
        scen_illegal();
        repeat (5) @(posedge sys_clk);
        scen_watchdog();
        repeat (5) @(posedge sys_clk);
        scen_external();
        repeat (5) @(posedge sys_clk);
        scen_power_on();
        print_verdict();
    end

    initial begin
        #(30000 * 8);
        n_mismatch++;
        print_verdict();
    end
endmodule
